// ==== hdl/adc_window_pkg.sv ====
// constants, register map and types of the window compare event logic
package adc_window_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] CMP_CTRL_OFS = 8'h00; // window_compare_control
  localparam logic [7:0] CMP_BCH_OFS = 8'h04; // window_b_channel_choice
  localparam logic [7:0] INT_STAT_OFS = 8'h08; // sticky event status, RO
  localparam logic [7:0] INT_CLR_OFS = 8'h0C; // write one to clear, WO
  localparam logic [7:0] INT_EN_OFS = 8'h10; // interrupt enable
  localparam logic [7:0] EVT_STATE_OFS = 8'h14; // last outcome, RO

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int COMBINE_LSB = 0; // window_combine_select [1:0]
  localparam int B_ENABLE_BIT = 9; // window_b_enable
  localparam int A_ENABLE_BIT = 11; // window_a_enable
  localparam int CHAN_W = 6; // window_b_channel_select width
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_MISMATCH_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [15:0] CMP_CTRL_RST = 16'h0000;
  localparam logic [5:0] CMP_BCH_RST = 6'h00;
  localparam logic [1:0] INT_EN_RST = 2'h0;

  // ****************************************************************
  // combining codes and channel codes
  // ****************************************************************
  localparam logic [1:0] COMBINE_OR = 2'h0;
  localparam logic [1:0] COMBINE_XOR = 2'h1;
  localparam logic [1:0] COMBINE_AND = 2'h2;
  localparam logic [1:0] COMBINE_RSVD = 2'h3;
  localparam logic [5:0] CH_LOW_LAST = 6'h07; // analog_input_0..7
  localparam logic [5:0] CH_HIGH_FIRST = 6'h10; // analog_input_16
  localparam logic [5:0] CH_HIGH_LAST = 6'h1F; // analog_input_31
  localparam logic [5:0] CH_TEMP = 6'h20; // temperature sensor
  localparam logic [5:0] CH_VREF = 6'h21; // internal reference voltage

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // control fields as the event logic sees them
  typedef struct packed {
    logic aEnable;
    logic bEnable;
    logic [1:0] combine;
  } cmp_ctrl_t;

  // one finished conversion with both window results
  typedef struct packed {
    logic valid;
    logic [5:0] channel;
    logic aMet;
    logic bMet;
  } conv_result_t;

endpackage

// ==== hdl/adc_window_compare_events.sv ====
// window A/B compare event combiner with an AHB-Lite register slave
// Function
// - select 00: match when window A or B met, else mismatch.
// - select 01: match only when exactly one window is met.
// - select 10: match only when both windows are met.
// - combination not satisfied gives mismatch event instead of match.
// - window B enable 0 suppresses match and mismatch outputs.
// - window A enable 0 suppresses match and mismatch outputs.
// - B codes 0-7, 16-31 are analog inputs; 100001 is reference voltage.
// - B code 100000 routes the temperature sensor result into window B.
`timescale 1ns/10ps
`default_nettype none

module adc_window_compare_events
  import adc_window_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // conversion results from the converter core
  input wire logic convValid,
  input wire logic [5:0] convChannel,
  input wire logic winAMet,
  input wire logic winBMet,
  // event link outputs
  output logic windowMatchEvent,
  output logic windowMismatchEvent,
  output logic irq
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************

  // true for every channel code that window B may legally select
  function automatic logic isLegalChannel(input logic [5:0] code);
    isLegalChannel = (code <= CH_LOW_LAST) ||
                     (code >= CH_HIGH_FIRST && code <= CH_HIGH_LAST) ||
                     (code == CH_TEMP) ||
                     (code == CH_VREF);
  endfunction

  // outcome of the chosen combination of window results
  function automatic logic combineMet(input logic [1:0] sel,
                                      input logic a,
                                      input logic b);
    case (sel)
      COMBINE_OR: combineMet = a | b;
      COMBINE_XOR: combineMet = a ^ b;
      COMBINE_AND: combineMet = a & b;
      default: combineMet = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [15:0] cmpCtrlReg;
  logic [5:0] bChannel;
  logic [STAT_W-1:0] intStatus;
  logic [STAT_W-1:0] intEnable;
  logic lastMatch;
  logic lastMismatch;
  logic dpWrite;
  logic [7:0] dpAddr;
  cmp_ctrl_t ctrl;
  conv_result_t conv;

  // control fields pulled from their bit positions
  assign ctrl.combine = cmpCtrlReg[COMBINE_LSB +: 2];
  assign ctrl.bEnable = cmpCtrlReg[B_ENABLE_BIT];
  assign ctrl.aEnable = cmpCtrlReg[A_ENABLE_BIT];

  // incoming result bundled for the event logic
  assign conv.valid = convValid;
  assign conv.channel = convChannel;
  assign conv.aMet = winAMet;
  assign conv.bMet = winBMet;

  // ****************************************************************
  // ahb-lite address and data phase
  // ****************************************************************
  logic addrPhase;
  logic wrStrobe;
  logic [31:0] readMux;

  // an active transfer is accepted when the bus is ready
  assign addrPhase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
  assign wrStrobe = dpWrite && hready;

  // read value for the address now on the bus; unmapped reads zero
  always_comb begin
    readMux = 32'h0000_0000;
    case (haddr)
      CMP_CTRL_OFS: readMux[15:0] = cmpCtrlReg;
      CMP_BCH_OFS: readMux[CHAN_W-1:0] = bChannel;
      INT_STAT_OFS: readMux[STAT_W-1:0] = intStatus;
      INT_EN_OFS: readMux[STAT_W-1:0] = intEnable;
      EVT_STATE_OFS: readMux[STAT_W-1:0] = {lastMismatch, lastMatch};
      default: readMux = 32'h0000_0000;
    endcase
  end

  // remember a write address phase for the following data phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        dpWrite <= addrPhase && hwrite;
        dpAddr <= haddr;
      end
    end
  end

  // read data registered so it stands through the data phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (addrPhase && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  // control and channel choice take the data phase word
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmpCtrlReg <= CMP_CTRL_RST;
      bChannel <= CMP_BCH_RST;
      intEnable <= INT_EN_RST;
    end else if (ce && wrStrobe) begin
      case (dpAddr)
        CMP_CTRL_OFS: cmpCtrlReg <= hwdata[15:0];
        CMP_BCH_OFS: bChannel <= hwdata[CHAN_W-1:0];
        INT_EN_OFS: intEnable <= hwdata[STAT_W-1:0];
        default: cmpCtrlReg <= cmpCtrlReg;
      endcase
    end
  end

  // ****************************************************************
  // window event evaluation
  // ****************************************************************
  logic onSelected;
  logic fire;
  logic met;

  // a result counts only on the legal, selected window B channel
  assign onSelected = conv.valid && isLegalChannel(bChannel) &&
                      (conv.channel == bChannel);
  // both windows enabled and a defined combination chosen
  assign fire = onSelected && ctrl.aEnable &&
                ctrl.bEnable &&
                (ctrl.combine != COMBINE_RSVD);
  assign met = combineMet(ctrl.combine, conv.aMet, conv.bMet);

  // one-cycle event pulses, mutually exclusive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      windowMatchEvent <= 1'b0;
      windowMismatchEvent <= 1'b0;
    end else if (ce) begin
      windowMatchEvent <= fire && met;
      windowMismatchEvent <= fire && !met;
    end
  end

  // outcome of the last evaluated conversion, for software
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lastMatch <= 1'b0;
      lastMismatch <= 1'b0;
    end else if (ce && fire) begin
      lastMatch <= met;
      lastMismatch <= !met;
    end
  end

  // ****************************************************************
  // interrupt status, clear and output
  // ****************************************************************
  logic [STAT_W-1:0] setMask;
  logic [STAT_W-1:0] clrMask;
  logic [STAT_W-1:0] next_status;

  assign setMask = {fire && !met, fire && met};
  assign clrMask = (wrStrobe && dpAddr == INT_CLR_OFS) ?
                   hwdata[STAT_W-1:0] : {STAT_W{1'b0}};

  // set wins over a clear landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < STAT_W; gi++) begin : g_status
      assign next_status[gi] = setMask[gi] ||
                               (intStatus[gi] && !clrMask[gi]);
    end
  endgenerate

  // sticky flags, then the level interrupt from enabled flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      intStatus <= {STAT_W{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      intStatus <= next_status;
      irq <= |(next_status & intEnable);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_or_match: assert property (@(posedge mclk) disable iff (!rstn)
    ce && fire && ctrl.combine == COMBINE_OR && (winAMet || winBMet)
    |=> windowMatchEvent && !windowMismatchEvent)
    else $error("or combination did not give a match");

  a_xor_match: assert property (@(posedge mclk) disable iff (!rstn)
    ce && fire && ctrl.combine == COMBINE_XOR && winAMet && winBMet
    |=> windowMismatchEvent && !windowMatchEvent)
    else $error("xor with both met did not give a mismatch");

  a_and_match: assert property (@(posedge mclk) disable iff (!rstn)
    ce && fire && ctrl.combine == COMBINE_AND && (winAMet != winBMet)
    |=> !windowMatchEvent ##0 windowMismatchEvent)
    else $error("and with one window met gave a match");

  a_events_exclusive: assert property (@(posedge mclk)
    disable iff (!rstn) !(windowMatchEvent && windowMismatchEvent))
    else $error("match and mismatch asserted together");

  a_reserved_silent: assert property (@(posedge mclk) disable iff (!rstn)
    ce && ctrl.combine == COMBINE_RSVD
    |=> !windowMatchEvent && !windowMismatchEvent)
    else $error("event emitted with reserved combination");

  a_b_disable: assert property (@(posedge mclk) disable iff (!rstn)
    ce && !ctrl.bEnable |=> !windowMatchEvent && !windowMismatchEvent)
    else $error("event emitted with window B disabled");

  a_a_disable: assert property (@(posedge mclk) disable iff (!rstn)
    ce && !ctrl.aEnable |=> !windowMatchEvent && !windowMismatchEvent)
    else $error("event emitted with window A disabled");

  a_temp_route: assert property (@(posedge mclk) disable iff (!rstn)
    ce && convValid && bChannel == CH_TEMP && convChannel == CH_TEMP &&
    ctrl.aEnable && ctrl.bEnable && ctrl.combine == COMBINE_AND &&
    winAMet && winBMet |=> windowMatchEvent)
    else $error("temperature sensor result not routed to window B");

  a_illegal_chan: assert property (@(posedge mclk) disable iff (!rstn)
    ce && !isLegalChannel(bChannel)
    |=> !windowMatchEvent && !windowMismatchEvent)
    else $error("event emitted on a forbidden channel code");

  a_once_per_conv: assert property (@(posedge mclk) disable iff (!rstn)
    (windowMatchEvent || windowMismatchEvent) && $past(ce) |->
    $past(convValid) && $past(convChannel) == $past(bChannel))
    else $error("event without a conversion on the selected channel");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    ce ##1 ce |-> irq == |($past(next_status) & $past(intEnable)))
    else $error("interrupt does not follow enabled status");

endmodule

`default_nettype wire

// ==== dv/adc_conv_source.sv ====
// converter core model that hands finished results to the compare logic
`timescale 1ns/10ps
`default_nettype none

module adc_conv_source
  import adc_window_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire conv_result_t req,
  output logic convValid,
  output logic [5:0] convChannel,
  output logic winAMet,
  output logic winBMet
);

  // ****************************************************************
  // result pulse
  // ****************************************************************
  // one pulse per requested result; the other lines churn when idle
  // so nothing can lean on a stale channel or window flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      convValid <= 1'b0;
      convChannel <= 6'h00;
      winAMet <= 1'b0;
      winBMet <= 1'b0;
    end else if (req.valid) begin
      convValid <= 1'b1;
      convChannel <= req.channel;
      winAMet <= req.aMet;
      winBMet <= req.bMet;
    end else begin
      convValid <= 1'b0;
      convChannel <= ~convChannel;
      winAMet <= ~winAMet;
      winBMet <= ~winBMet;
    end
  end

endmodule
`default_nettype wire

// ==== dv/adc_window_compare_events_test.sv ====
// self-checking testbench of the window compare event logic
`timescale 1ns/10ps
`default_nettype none

module adc_window_compare_events_test
  import adc_window_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic ce = 1'b1;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, match, mismatch, irq;
  logic convValid, winAMet, winBMet, aMet, bMet;
  logic [5:0] convChannel, ch;
  conv_result_t req = '0;
  logic [1:0] q[$];
  logic [7:0] ofs [6] = '{CMP_CTRL_OFS, CMP_BCH_OFS, INT_STAT_OFS,
    INT_CLR_OFS, INT_EN_OFS, EVT_STATE_OFS};
  logic [5:0] chs [6] = '{6'h00, CH_LOW_LAST, CH_HIGH_FIRST,
    CH_HIGH_LAST, CH_TEMP, CH_VREF};
  int errorCnt = 0;
  int totalChecks = 0;
  int seed = 82;

  adc_window_compare_events u_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .convValid(convValid),
    .convChannel(convChannel), .winAMet(winAMet), .winBMet(winBMet),
    .windowMatchEvent(match), .windowMismatchEvent(mismatch), .irq(irq));

  adc_conv_source u_src (.mclk(mclk), .rstn(rstn), .req(req),
    .convValid(convValid), .convChannel(convChannel),
    .winAMet(winAMet), .winBMet(winBMet));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one single ahb-lite transfer, zero or more wait states
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("bus response", 32'h2, {30'h0, hreadyout, hresp});
  endtask

  // request a result; note the expected outcome when one is due
  task automatic conv(input logic [5:0] c, input logic a, input logic b,
                      input logic ev, input logic m);
    @(posedge mclk);
    req <= '{1'b1, c, a, b};
    if (ev) q.push_back({m, ~m});
  endtask

  task automatic idle(input int n);
    @(posedge mclk);
    req <= '0;
    repeat (n) @(posedge mclk);
  endtask

  function automatic logic [31:0] ctrl(input logic ae, input logic be,
                                       input logic [1:0] c);
    return {20'h0, ae, 1'b0, be, 7'h0, c};
  endfunction

  function automatic logic expm(input logic [1:0] c, input logic a,
                                input logic b);
    case (c)
      COMBINE_OR: return a | b;
      COMBINE_XOR: return a ^ b;
      default: return a & b;
    endcase
  endfunction

  // random legal channel code: inputs 0-7, 16-31, sensor, reference
  function automatic logic [5:0] legal();
    int k;
    k = int'($unsigned($random(seed)) % 26);
    return 6'(k < 8 ? k : k + 8);
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // clock, event monitor, watchdog
  // ****************************************************************
  initial forever #5 mclk = ~mclk;

  // every event pulse takes the oldest note off the queue
  always @(posedge mclk) begin
    if (match === 1'b1 || mismatch === 1'b1) begin
      if (q.size() == 0) chk("stray event", 32'h0, {match, mismatch});
      else chk("event", {30'h0, q.pop_front()}, {match, mismatch});
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    results();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ofs[i]) rdchk("reset value", ofs[i], 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    bus(1'b1, CMP_BCH_OFS, 32'h3F);
    rdchk("channel reg", CMP_BCH_OFS, 32'h3F);
    bus(1'b1, CMP_CTRL_OFS, 32'hFFFFFFFF);
    rdchk("control reg", CMP_CTRL_OFS, 32'hFFFF);
    // reserved select: no event at all
    bus(1'b1, CMP_BCH_OFS, 32'h05);
    conv(6'h05, 1'b1, 1'b1, 1'b0, 1'b0);
    idle(3);
    // each defined combining code, random results, back to back
    for (int c = 0; c < 3; c++) begin
      ch = legal();
      bus(1'b1, CMP_BCH_OFS, {26'h0, ch});
      bus(1'b1, CMP_CTRL_OFS, ctrl(1'b1, 1'b1, c[1:0]));
      for (int i = 0; i < 8; i++) begin
        // all four result pairs first, then random ones
        aMet = (i < 4) ? i[1] : 1'($random(seed));
        bMet = (i < 4) ? i[0] : 1'($random(seed));
        conv(ch, aMet, bMet, 1'b1, expm(c[1:0], aMet, bMet));
      end
      conv(ch ^ 6'h01, 1'b1, 1'b1, 1'b0, 1'b0);
      idle(3);
    end
    // boundary channel codes, sensor and reference
    foreach (chs[i]) begin
      bus(1'b1, CMP_BCH_OFS, {26'h0, chs[i]});
      conv(chs[i], ~i[0], 1'b1, 1'b1, ~i[0]);
      idle(2);
    end
    bus(1'b1, CMP_BCH_OFS, 32'h08);
    conv(6'h08, 1'b1, 1'b1, 1'b0, 1'b0);
    idle(2);
    bus(1'b1, CMP_BCH_OFS, 32'h02);
    bus(1'b1, CMP_CTRL_OFS, ctrl(1'b1, 1'b0, COMBINE_OR));
    conv(6'h02, 1'b1, 1'b1, 1'b0, 1'b0);
    idle(2);
    bus(1'b1, CMP_CTRL_OFS, ctrl(1'b0, 1'b1, COMBINE_OR));
    conv(6'h02, 1'b1, 1'b1, 1'b0, 1'b0);
    idle(2);
    // frozen clock enable: a result on the selected channel is lost
    bus(1'b1, CMP_CTRL_OFS, ctrl(1'b1, 1'b1, COMBINE_OR));
    ce <= 1'b0;
    conv(6'h02, 1'b1, 1'b1, 1'b0, 1'b0);
    idle(3);
    ce <= 1'b1;
    // interrupt: clear, mask, raise, clear again
    bus(1'b1, CMP_CTRL_OFS, ctrl(1'b1, 1'b1, COMBINE_AND));
    bus(1'b1, INT_CLR_OFS, 32'h3);
    bus(1'b1, INT_EN_OFS, 32'h1);
    rdchk("status", INT_STAT_OFS, 32'h0);
    conv(6'h02, 1'b1, 1'b0, 1'b1, 1'b0);
    idle(3);
    chk("masked irq", 32'h0, {31'h0, irq});
    rdchk("status", INT_STAT_OFS, 32'h2);
    rdchk("outcome", EVT_STATE_OFS, 32'h2);
    conv(6'h02, 1'b1, 1'b1, 1'b1, 1'b1);
    idle(3);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, INT_STAT_OFS, 32'h0);
    rdchk("status", INT_STAT_OFS, 32'h3);
    bus(1'b1, INT_CLR_OFS, 32'h1);
    idle(3);
    chk("cleared irq", 32'h0, {31'h0, irq});
    rdchk("status", INT_STAT_OFS, 32'h2);
    rdchk("clear reg", INT_CLR_OFS, 32'h0);
    chk("pending notes", 32'h0, q.size());
    results();
  end

endmodule
`default_nettype wire
